// *** logic/pdcds_interval_timer.sv ***
// Restartable interval timer that pulses when its limit has elapsed.
`timescale 1ns/1ps

module pdcds_interval_timer (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_start,
  input  wire logic                  i_stop,
  input  wire pdcds_pkg::pdcds_cnt_t i_limit,
  output logic                       o_expired,
  output logic                       o_running
);
  import pdcds_pkg::*;

  pdcds_cnt_t cnt_r;
  pdcds_cnt_t cnt_nxt;
  logic       run_r;
  logic       run_nxt;
  logic       exp_r;
  logic       exp_nxt;

  // The pulse comes i_limit + 1 cycles after the start pulse, for any i_limit of 1 or more.
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (i_start) begin
      cnt_nxt = pdcds_cnt_t'(1);
      run_nxt = 1'b1;
    end else if (i_stop) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r >= i_limit) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + pdcds_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign o_expired = exp_r;
  assign o_running = run_r;

endmodule : pdcds_interval_timer

// *** logic/pdcds_sink.sv ***
// Sink-side policy engine for a negotiated current decrease.
`timescale 1ns/1ps
`include "pdcds_cfg.svh"

module pdcds_sink #(
  parameter pdcds_pkg::pdcds_cnt_t WATCH_CYC = pdcds_pkg::pdcds_cnt_t'(`PDCDS_WATCH_CYC)
) (
  input  wire logic      i_sys_clk,
  input  wire logic      i_rst_n,
  pdcds_link_if.sink     link,
  input  wire logic      i_load_low,
  output logic           o_reduce_load,
  output logic           o_busy,
  output logic           o_done,
  output logic           o_load_late,
  output logic           o_error
);
  import pdcds_pkg::*;

  typedef enum logic [2:0] {
    PDCDS_SNK_IDLE = 3'h1,
    PDCDS_SNK_EVAL = 3'h2,
    PDCDS_SNK_WAIT = 3'h4
  } pdcds_snk_state_e;

  pdcds_snk_state_e state_r;
  pdcds_snk_state_e state_nxt;

  logic crc_r;
  logic crc_nxt;
  logic reduce_r;
  logic reduce_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  logic late_r;
  logic late_nxt;
  logic err_r;
  logic err_nxt;
  logic low_r;
  logic low_nxt;

  logic watch_start;
  logic watch_stop;
  logic watch_expired;
  logic load_start;
  logic load_expired;

  pdcds_interval_timer u_watch_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (watch_start),
    .i_stop    (watch_stop),
    .i_limit   (WATCH_CYC),
    .o_expired (watch_expired),
    .o_running ()
  );

  pdcds_interval_timer u_load_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (load_start),
    .i_stop    (1'b0),
    .i_limit   (pdcds_cnt_t'(`PDCDS_REDUCED_LOAD_CYC)),
    .o_expired (load_expired),
    .o_running ()
  );

  // The protocol layer acknowledges every message it receives, even one out of sequence.
  always_comb begin
    state_nxt   = state_r;
    crc_nxt     = link.msg_vld;
    reduce_nxt  = 1'b0;
    busy_nxt    = busy_r;
    done_nxt    = 1'b0;
    late_nxt    = 1'b0;
    err_nxt     = 1'b0;
    low_nxt     = low_r | i_load_low;
    watch_start = 1'b0;
    watch_stop  = 1'b0;
    load_start  = 1'b0;
    case (state_r)
      PDCDS_SNK_IDLE: begin
        busy_nxt = 1'b0;
        low_nxt  = 1'b0;
        if (link.msg_vld && link.msg_type == PDCDS_MSG_ACCEPT) begin
          state_nxt   = PDCDS_SNK_EVAL;
          watch_start = 1'b1;
          busy_nxt    = 1'b1;
        end
      end
      PDCDS_SNK_EVAL: begin
        state_nxt  = PDCDS_SNK_WAIT;
        reduce_nxt = 1'b1;
        load_start = 1'b1;
      end
      PDCDS_SNK_WAIT: begin
        if (link.msg_vld && link.msg_type == PDCDS_MSG_PS_RDY) begin
          state_nxt  = PDCDS_SNK_IDLE;
          watch_stop = 1'b1;
          done_nxt   = 1'b1;
          busy_nxt   = 1'b0;
        end else if (watch_expired) begin
          state_nxt = PDCDS_SNK_IDLE;
          err_nxt   = 1'b1;
          busy_nxt  = 1'b0;
        end
        // A late load drop is flagged but the sequence goes on.
        if (load_expired && !low_r && !i_load_low) begin
          late_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = PDCDS_SNK_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= PDCDS_SNK_IDLE;
      crc_r    <= 1'b0;
      reduce_r <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      late_r   <= 1'b0;
      err_r    <= 1'b0;
      low_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      crc_r    <= crc_nxt;
      reduce_r <= reduce_nxt;
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
      late_r   <= late_nxt;
      err_r    <= err_nxt;
      low_r    <= low_nxt;
    end
  end

  assign link.crc_ack  = crc_r;
  assign o_reduce_load = reduce_r;
  assign o_busy        = busy_r;
  assign o_done        = done_r;
  assign o_load_late   = late_r;
  assign o_error       = err_r;

endmodule : pdcds_sink

// *** logic/pdcds_source.sv ***
// Source-side policy engine for a negotiated current decrease.
// Steps of the sequence on both sides, source and sink
// - Source answers pending request with Accept
// - Sink starts watch timer on Accept
// - Every message acknowledged; sender waits for it
// - Source waits settle interval after Accept ack
// - Sink orders its supply to lower load
// - Sink reaches lower load before settle ends
// - After settle, source orders supply change
// - Supply ready within source-ready interval, reported
// - Source sends PS_RDY after readiness
// - Sink acknowledges PS_RDY, sequence ends
`timescale 1ns/1ps
`include "pdcds_cfg.svh"

module pdcds_source #(
  parameter pdcds_pkg::pdcds_cnt_t SRC_READY_CYC = pdcds_pkg::pdcds_cnt_t'(`PDCDS_SRC_READY_CYC)
) (
  input  wire logic      i_sys_clk,
  input  wire logic      i_rst_n,
  pdcds_link_if.source   link,
  input  wire logic      i_req_ok,
  input  wire logic      i_supply_ready,
  output logic           o_supply_change,
  output logic           o_busy,
  output logic           o_done,
  output logic           o_ready_late
);
  import pdcds_pkg::*;

  // One-hot states written out; a corrupted code is caught by the default branch
  // and returns the engine to idle rather than locking it.
  typedef enum logic [7:0] {
    PDCDS_SRC_IDLE    = 8'h01,
    PDCDS_SRC_ACC_TX  = 8'h02,
    PDCDS_SRC_ACC_ACK = 8'h04,
    PDCDS_SRC_SETTLE  = 8'h08,
    PDCDS_SRC_RECFG   = 8'h10,
    PDCDS_SRC_READY   = 8'h20,
    PDCDS_SRC_RDY_TX  = 8'h40,
    PDCDS_SRC_RDY_ACK = 8'h80
  } pdcds_src_state_e;

  pdcds_src_state_e state_r;
  pdcds_src_state_e state_nxt;

  // Every output and link signal leaves from a register so that the far end sees clean pulses.
  logic       msg_vld_r;
  logic       msg_vld_nxt;
  pdcds_msg_e msg_type_r;
  pdcds_msg_e msg_type_nxt;
  logic       change_r;
  logic       change_nxt;
  logic       busy_r;
  logic       busy_nxt;
  logic       done_r;
  logic       done_nxt;
  logic       late_r;
  logic       late_nxt;

  logic       settle_start;
  logic       settle_expired;
  logic       ready_start;
  logic       ready_stop;
  logic       ready_expired;

  // The settle timer is never stopped, so the only way out of the settle state is its expiry.
  pdcds_interval_timer u_settle_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (settle_start),
    .i_stop    (1'b0),
    .i_limit   (pdcds_cnt_t'(`PDCDS_SETTLE_CYC)),
    .o_expired (settle_expired),
    .o_running ()
  );

  // Stopping the ready timer on readiness keeps its pulse from surfacing after the sequence moved on.
  pdcds_interval_timer u_ready_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (ready_start),
    .i_stop    (ready_stop),
    .i_limit   (SRC_READY_CYC),
    .o_expired (ready_expired),
    .o_running ()
  );

  // Sequencing. A request that arrives while a sequence runs is not queued;
  // the local manager must hold i_req_ok until o_busy rises.
  always_comb begin
    // Pulses default low each cycle; levels and the message type hold their value.
    state_nxt    = state_r;
    msg_vld_nxt  = 1'b0;
    msg_type_nxt = msg_type_r;
    change_nxt   = 1'b0;
    busy_nxt     = busy_r;
    done_nxt     = 1'b0;
    late_nxt     = 1'b0;
    settle_start = 1'b0;
    ready_start  = 1'b0;
    ready_stop   = 1'b0;
    case (state_r)
      // Idle keeps busy low; every ending state also lowers it on the edge that returns here.
      PDCDS_SRC_IDLE: begin
        busy_nxt = 1'b0;
        if (i_req_ok) begin
          state_nxt    = PDCDS_SRC_ACC_TX;
          msg_vld_nxt  = 1'b1;
          msg_type_nxt = PDCDS_MSG_ACCEPT;
          busy_nxt     = 1'b1;
        end
      end

      // The Accept pulse is on the link now; its acknowledge can come no sooner than next cycle.
      PDCDS_SRC_ACC_TX: begin
        state_nxt = PDCDS_SRC_ACC_ACK;
      end

      // No timeout here: a far end that never acknowledges leaves the engine waiting until reset.
      PDCDS_SRC_ACC_ACK: begin
        if (link.crc_ack) begin
          state_nxt    = PDCDS_SRC_SETTLE;
          settle_start = 1'b1;
        end
      end

      // The change order is one pulse, given once the settle interval has run out in full.
      PDCDS_SRC_SETTLE: begin
        if (settle_expired) begin
          state_nxt  = PDCDS_SRC_RECFG;
          change_nxt = 1'b1;
        end
      end

      // The ready interval is counted from the cycle in which the change order stands.
      PDCDS_SRC_RECFG: begin
        state_nxt   = PDCDS_SRC_READY;
        ready_start = 1'b1;
      end

      // The supply input is looked at only here; outside this state it is ignored.
      PDCDS_SRC_READY: begin
        // Readiness seen in the same cycle as the expiry still counts.
        if (i_supply_ready) begin
          state_nxt    = PDCDS_SRC_RDY_TX;
          ready_stop   = 1'b1;
          msg_vld_nxt  = 1'b1;
          msg_type_nxt = PDCDS_MSG_PS_RDY;
        end else if (ready_expired) begin
          state_nxt = PDCDS_SRC_IDLE;
          late_nxt  = 1'b1;
          busy_nxt  = 1'b0;
        end
      end

      // Same one-cycle gap as after Accept before the acknowledge is looked for.
      PDCDS_SRC_RDY_TX: begin
        state_nxt = PDCDS_SRC_RDY_ACK;
      end

      // In this state the sequence closes only once the sink has acknowledged the ready message.
      PDCDS_SRC_RDY_ACK: begin
        if (link.crc_ack) begin
          state_nxt = PDCDS_SRC_IDLE;
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
        end
      end

      // An illegal code drops the sequence without any message or pulse.
      default: begin
        state_nxt = PDCDS_SRC_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  // Reset leaves the link quiet with the type parked at Accept, which is ignored while valid is low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r    <= PDCDS_SRC_IDLE;
      msg_vld_r  <= 1'b0;
      msg_type_r <= PDCDS_MSG_ACCEPT;
      change_r   <= 1'b0;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      late_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      msg_vld_r  <= msg_vld_nxt;
      msg_type_r <= msg_type_nxt;
      change_r   <= change_nxt;
      busy_r     <= busy_nxt;
      done_r     <= done_nxt;
      late_r     <= late_nxt;
    end
  end

  // The link is driven only from registers, so the sink never samples a combinational glitch.
  assign link.msg_vld    = msg_vld_r;
  assign link.msg_type   = msg_type_r;
  assign o_supply_change = change_r;
  assign o_busy          = busy_r;
  assign o_done          = done_r;
  assign o_ready_late    = late_r;

endmodule : pdcds_source

// *** pkg/pdcds_cfg.svh ***
// Timing and width constants for the current-decrease sequencer.
`ifndef PDCDS_CFG_SVH
`define PDCDS_CFG_SVH

`define PDCDS_CLK_PERIOD_NS   10
`define PDCDS_CNT_W           20
`define PDCDS_SETTLE_US       30
`define PDCDS_SRC_READY_US    280
`define PDCDS_REDUCED_LOAD_US 20
`define PDCDS_WATCH_US        600

// A least time rounds up to whole cycles, a longest time rounds down.
`define PDCDS_CYC_UP(us) (((us) * 1000 + `PDCDS_CLK_PERIOD_NS - 1) / `PDCDS_CLK_PERIOD_NS)
`define PDCDS_CYC_DN(us) (((us) * 1000) / `PDCDS_CLK_PERIOD_NS)

`define PDCDS_SETTLE_CYC       `PDCDS_CYC_UP(`PDCDS_SETTLE_US)
`define PDCDS_SRC_READY_CYC    `PDCDS_CYC_DN(`PDCDS_SRC_READY_US)
`define PDCDS_REDUCED_LOAD_CYC `PDCDS_CYC_DN(`PDCDS_REDUCED_LOAD_US)
`define PDCDS_WATCH_CYC        `PDCDS_CYC_DN(`PDCDS_WATCH_US)

`endif

// *** pkg/pdcds_link_if.sv ***
// Message link between the source and sink policy engines.
`timescale 1ns/1ps

interface pdcds_link_if;
  import pdcds_pkg::*;

  logic       msg_vld;
  pdcds_msg_e msg_type;
  logic       crc_ack;

  modport source (
    output msg_vld,
    output msg_type,
    input  crc_ack
  );

  modport sink (
    input  msg_vld,
    input  msg_type,
    output crc_ack
  );

endinterface : pdcds_link_if

// *** pkg/pdcds_pkg.sv ***
// Shared types of the current-decrease sequencer.
`include "pdcds_cfg.svh"

package pdcds_pkg;

  typedef logic [`PDCDS_CNT_W-1:0] pdcds_cnt_t;

  typedef enum logic [1:0] {
    PDCDS_MSG_ACCEPT = 2'h1,
    PDCDS_MSG_PS_RDY = 2'h2
  } pdcds_msg_e;

endpackage : pdcds_pkg

// *** tb/pd_current_decrease_sequencer_tb.sv ***
// Self-checking bench for the source and sink policy engines joined by one link.
`timescale 1ns/1ps
`include "pdcds_cfg.svh"

module pd_current_decrease_sequencer_tb;
  import pdcds_pkg::*;
  // Short timers keep the run small; the watch still exceeds settle plus ready.
  localparam pdcds_cnt_t RDY_CYC   = 20'h32;
  localparam pdcds_cnt_t WATCH_CYC = 20'hc80;
  localparam int         SETTLE    = `PDCDS_SETTLE_CYC;

  logic i_sys_clk    = 1'b0;
  logic i_rst_n      = 1'b0;
  logic req_ok       = 1'b0;
  logic supply_ready = 1'b0;
  logic load_low     = 1'b0;
  logic src_change, src_busy, src_done, src_late;
  logic snk_reduce, snk_busy, snk_done, snk_late, snk_err;
  int   miscompares  = 0;
  int   cmp_count    = 0;
  int   cyc          = 0;

  pdcds_link_if link ();
  always #5 i_sys_clk = ~i_sys_clk;

  pdcds_source #(.SRC_READY_CYC(RDY_CYC)) u_pdcds_source (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .link(link), .i_req_ok(req_ok), .i_supply_ready(supply_ready), .o_supply_change(src_change),
    .o_busy(src_busy), .o_done(src_done), .o_ready_late(src_late));
  pdcds_sink #(.WATCH_CYC(WATCH_CYC)) u_pdcds_sink (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .link(link), .i_load_low(load_low), .o_reduce_load(snk_reduce), .o_busy(snk_busy),
    .o_done(snk_done), .o_load_late(snk_late), .o_error(snk_err));
  pdcds_link_props u_pdcds_link_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .msg_vld(link.msg_vld), .msg_type(link.msg_type), .crc_ack(link.crc_ack));

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic tick();
    @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_cnt(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  // One cycle for the acknowledge to start the settle timer, the full interval, one for the order register.
  function automatic int change_gap();
    return SETTLE + 2;
  endfunction : change_gap

  // A negative ready delay means the supply never reports ready.
  task automatic run_seq(input int d, input int load_at);
    int n;
    int c0;
    bit late_seen;
    bit vld_seen;
    req_ok = 1'b1;
    tick();
    req_ok = 1'b0;
    c0 = cyc;
    chk_bit("accept", 1'b1, link.msg_vld && link.msg_type == PDCDS_MSG_ACCEPT);
    chk_bit("src_busy", 1'b1, src_busy);
    tick();
    chk_bit("accept_ack", 1'b1, link.crc_ack);
    chk_bit("snk_busy", 1'b1, snk_busy);
    n = 0;
    late_seen = 1'b0;
    vld_seen = 1'b0;
    while (src_change !== 1'b1 && n < 4000) begin
      req_ok = (n < SETTLE - 10) ? 1'($urandom) : 1'b0;
      supply_ready = (n < SETTLE - 10) ? 1'($urandom) : 1'b0;
      if (n == load_at) begin
        load_low = 1'b1;
      end
      tick();
      n++;
      if (n == 1) begin
        chk_bit("reduce_load", 1'b1, snk_reduce);
      end
      late_seen |= (snk_late === 1'b1);
      vld_seen |= (link.msg_vld === 1'b1);
    end
    chk_cnt("settle_gap", change_gap(), n);
    chk_bit("quiet_in_settle", 1'b0, vld_seen);
    chk_bit("load_late", 1'(load_at < 0), late_seen);
    if (d < 0) begin
      n = 0;
      while (src_late !== 1'b1 && n < 100) begin
        tick();
        n++;
        vld_seen |= (link.msg_vld === 1'b1);
      end
      chk_bit("ready_late", 1'b1, src_late && n >= int'(RDY_CYC) && n <= int'(RDY_CYC) + 4);
      chk_bit("no_ps_rdy", 1'b0, vld_seen);
      while (snk_err !== 1'b1 && cyc - c0 < 4000) begin
        tick();
      end
      chk_bit("watch_error", 1'b1, snk_err && cyc - c0 >= int'(WATCH_CYC) && cyc - c0 <= int'(WATCH_CYC) + 3);
      tick();
      chk_bit("snk_abandon", 1'b0, snk_busy);
    end else begin
      repeat (d) tick();
      supply_ready = 1'b1;
      tick();
      supply_ready = 1'b0;
      chk_bit("ps_rdy", 1'b1, link.msg_vld && link.msg_type == PDCDS_MSG_PS_RDY);
      tick();
      chk_bit("ps_rdy_ack", 1'b1, link.crc_ack && snk_done);
      chk_bit("snk_idle", 1'b0, snk_busy);
      tick();
      chk_bit("src_done", 1'b1, src_done && !src_busy);
    end
    load_low = 1'b0;
  endtask : run_seq

  initial begin
    void'($urandom(32'h2e7abca2));
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    tick();
    chk_bit("idle_after_reset", 1'b0, link.msg_vld | src_busy | snk_busy);
    run_seq(1, 5);
    run_seq(int'(RDY_CYC) - 5, -1);
    run_seq(-1, 10);
    run_seq(int'(RDY_CYC) + 1, 7);
    repeat (3) run_seq(1 + int'($urandom_range(40)), ($urandom_range(3) == 0) ? -1 : int'($urandom_range(1500)));
    give_verdict();
  end
endmodule : pd_current_decrease_sequencer_tb

// *** tb/pdcds_link_props.sv ***
// Checker of the message link between the source and sink policy engines.
`timescale 1ns/1ps
`include "pdcds_cfg.svh"

module pdcds_link_props
  import pdcds_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       msg_vld,
  input wire pdcds_msg_e msg_type,
  input wire logic       crc_ack
);
  localparam int SETTLE_CYC = `PDCDS_SETTLE_CYC;

  logic        acc_open_r;
  logic        acc_open_nxt;
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;

  // The gap counter saturates so a long idle spell cannot wrap into a false short gap.
  always_comb begin
    acc_open_nxt = acc_open_r;
    gap_nxt      = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h1;
    if (msg_vld) begin
      acc_open_nxt = (msg_type == PDCDS_MSG_ACCEPT);
      gap_nxt      = 16'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_open_r <= 1'b0;
      gap_r      <= 16'h0;
    end else begin
      acc_open_r <= acc_open_nxt;
      gap_r      <= gap_nxt;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_ack_follows; msg_vld |=> crc_ack; endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("acknowledge missing after a message");
  property p_ack_cause; crc_ack |-> $past(msg_vld); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without a message");
  property p_msg_pulse; msg_vld |=> !msg_vld; endproperty
  a_msg_pulse: assert property (p_msg_pulse)
    else $error("message valid longer than one cycle");
  property p_type_legal; msg_vld |-> msg_type inside {PDCDS_MSG_ACCEPT, PDCDS_MSG_PS_RDY}; endproperty
  a_type_legal: assert property (p_type_legal)
    else $error("message type not legal");
  property p_type_holds; !msg_vld |-> $stable(msg_type); endproperty
  a_type_holds: assert property (p_type_holds)
    else $error("message type moved while idle");
  property p_first_accept; msg_vld && !acc_open_r |-> msg_type == PDCDS_MSG_ACCEPT; endproperty
  a_first_accept: assert property (p_first_accept)
    else $error("sequence opened without accept");
  property p_rdy_after_acc; msg_vld && msg_type == PDCDS_MSG_PS_RDY |-> acc_open_r; endproperty
  a_rdy_after_acc: assert property (p_rdy_after_acc)
    else $error("ready message without accept");
  property p_settle_gap; msg_vld && acc_open_r |-> gap_r >= 16'(SETTLE_CYC); endproperty
  a_settle_gap: assert property (p_settle_gap)
    else $error("message sent inside settle interval");
endmodule : pdcds_link_props
